// File: logic/mrfd_defines.svh
/*
  Constants for the mode register field decoder: select codes, field positions,
  decode results and spacing/lock-time figures.
  Assumes inclusion by bare name from the package and the decoder module.
*/
`ifndef MRFD_DEFINES_SVH
`define MRFD_DEFINES_SVH

`define MRFD_SEL_CTRL_WORD    3'h7
`define MRFD_SEL_TERM         3'h1
`define MRFD_SEL_PARK         3'h5
`define MRFD_SEL_SPACING      3'h6
`define MRFD_NUM_REGS         7
`define MRFD_ADDR_W           18
`define MRFD_TERM_NOM_HI      9
`define MRFD_TERM_NOM_MID     6
`define MRFD_TERM_NOM_LO      2
`define MRFD_PARK_HI          8
`define MRFD_PARK_LO          6
`define MRFD_PAR_HI           2
`define MRFD_PAR_LO           0
`define MRFD_ODT_BUF_BIT      5
`define MRFD_SPC_HI           12
`define MRFD_SPC_LO           10
`define MRFD_TRAIN_EN_BIT     7
`define MRFD_TRAIN_RANGE_BIT  6
`define MRFD_TRAIN_VAL_HI     5
`define MRFD_TRAIN_VAL_LO     0
`define MRFD_TRAIN_VAL_MAX    6'h32
`define MRFD_RSV_MASK         18'h22300
`define MRFD_PAR_MAX_CODE     3'h4
`define MRFD_SPC_MAX_CODE     3'h4
`define MRFD_SPC_BASE         4'h4
`define MRFD_PAR_LAT_4        4'h4
`define MRFD_PAR_LAT_5        4'h5
`define MRFD_PAR_LAT_6        4'h6
`define MRFD_PAR_LAT_8        4'h8
`define MRFD_DLLK_0           11'h255
`define MRFD_DLLK_1           11'h187
`define MRFD_DLLK_2           11'h300
`define MRFD_DLLK_3           11'h400
`define MRFD_ZERO_4           4'h0
`define MRFD_ZERO_11          11'h000
`define MRFD_ZERO_3           3'h0
`define MRFD_ZERO_6           6'h00
`define MRFD_ZERO_18          18'h00000

`endif

// File: logic/mrfd_pkg.sv
/*
  Types for the mode register field decoder.
  Assumes mrfd_defines.svh is on the include path.
*/
`include "mrfd_defines.svh"

package mrfd_pkg;

  // One mode-register-set command as seen on the command/address bus
  typedef struct packed {
    logic                      valid;
    logic                      bankGroup1;
    logic [2:0]                select;
    logic [`MRFD_ADDR_W-1:0]   opcode;
  } mrfd_cmd_s;

  // Decoded park termination divider
  typedef enum logic [3:0] {
    MRFD_PARK_OFF,
    MRFD_PARK_DIV4,
    MRFD_PARK_DIV2,
    MRFD_PARK_DIV6,
    MRFD_PARK_DIV1,
    MRFD_PARK_DIV5,
    MRFD_PARK_DIV3,
    MRFD_PARK_DIV7
  } mrfd_park_e;

  // Decoded configuration handed to the rest of the device
  typedef struct packed {
    mrfd_park_e  parkTerm;
    logic        odtBufOff;
    logic        parityOn;
    logic [3:0]  parityLatency;
    logic        parityReserved;
    logic [3:0]  columnSpacing;
    logic [10:0] dllLockTime;
    logic        spacingReserved;
    logic        trainEnable;
    logic        trainRange;
    logic [5:0]  trainValue;
    logic        trainReserved;
    logic        reservedBitsSet;
  } mrfd_cfg_s;

  typedef logic [`MRFD_ADDR_W-1:0] mrfd_word_t;

endpackage

// File: logic/mrfd_decoder.sv
/*
  Mode register bank and field decoder: latches opcodes of mode-register-set
  commands into seven registers and decodes park termination, parity latency,
  column spacing, lock time and reference-level training fields.
  Assumes the command decoder upstream presents one-cycle valid commands on clk.
*/
// Summary of operation
// - Select code 000 to 110 picks mode register zero through six.
// - Select code 111 is a buffer control word; ignore it completely.
// - With nominal termination off, bit 5 of parity/park register is ignored.
// - Parity latency 000 off; 001-100 give 4,5,6,8 clocks; rest reserved.
// - Spacing field 000-100 give 4-8 clocks; 101-111 reserved.
// - Bit 7 high enters reference-level training, low is normal.
// - Bit 6 picks training range one (0) or two (1).
// - Six-bit training value steps level; codes up to 110010 valid.
// - Park field at bits 8:6, parity latency at bits 2:0.
`timescale 1ns/10ps
`default_nettype none
`include "mrfd_defines.svh"

module mrfd_decoder (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire mrfd_pkg::mrfd_cmd_s cmd,
  output var  mrfd_pkg::mrfd_cfg_s cfg,
  output var  mrfd_pkg::mrfd_word_t regView [`MRFD_NUM_REGS]
);
  import mrfd_pkg::*;

  mrfd_word_t modeReg_q [`MRFD_NUM_REGS];
  mrfd_word_t modeReg_d [`MRFD_NUM_REGS];
  mrfd_cfg_s  cfg_q;
  mrfd_cfg_s  cfg_d;

  // Nominal termination is off when its three bits are all zero
  function automatic logic termNomOff(input mrfd_word_t w);
    termNomOff = ~(w[`MRFD_TERM_NOM_HI] | w[`MRFD_TERM_NOM_MID] | w[`MRFD_TERM_NOM_LO]);
  endfunction

  // Lock time paired with a spacing code; reserved codes give zero
  function automatic logic [10:0] lockTime(input logic [2:0] code);
    unique case (code)
      3'h0:    lockTime = `MRFD_DLLK_0;
      3'h1:    lockTime = `MRFD_DLLK_1;
      3'h2:    lockTime = `MRFD_DLLK_2;
      3'h3,
      3'h4:    lockTime = `MRFD_DLLK_3;
      default: lockTime = `MRFD_ZERO_11;
    endcase
  endfunction

  // Parity latency in clocks; zero when off or reserved
  function automatic logic [3:0] parityClocks(input logic [2:0] code);
    unique case (code)
      3'h1:    parityClocks = `MRFD_PAR_LAT_4;
      3'h2:    parityClocks = `MRFD_PAR_LAT_5;
      3'h3:    parityClocks = `MRFD_PAR_LAT_6;
      3'h4:    parityClocks = `MRFD_PAR_LAT_8;
      default: parityClocks = `MRFD_ZERO_4;
    endcase
  endfunction

  // Register bank write: only the selected register takes the opcode
  always_comb begin
    for (int i = 0; i < `MRFD_NUM_REGS; i++) begin
      modeReg_d[i] = modeReg_q[i];
    end
    if (cmd.valid && cmd.select != `MRFD_SEL_CTRL_WORD) begin
      modeReg_d[cmd.select] = cmd.opcode;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < `MRFD_NUM_REGS; i++) begin
      if (reset) begin
        modeReg_q[i] <= `MRFD_ZERO_18;
      end else begin
        modeReg_q[i] <= modeReg_d[i];
      end
    end
  end

  // Field decode from the next register values so cfg lines up with regView
  always_comb begin
    mrfd_word_t park;
    mrfd_word_t spc;
    logic [2:0] parCode;
    logic [2:0] spcCode;
    park    = modeReg_d[`MRFD_SEL_PARK];
    spc     = modeReg_d[`MRFD_SEL_SPACING];
    parCode = park[`MRFD_PAR_HI:`MRFD_PAR_LO];
    spcCode = spc[`MRFD_SPC_HI:`MRFD_SPC_LO];
    cfg_d   = '0;
    cfg_d.parkTerm = mrfd_park_e'({1'b0, park[`MRFD_PARK_HI:`MRFD_PARK_LO]});
    // Buffer bit only means something while nominal termination is on
    cfg_d.odtBufOff = termNomOff(modeReg_d[`MRFD_SEL_TERM]) ? 1'b0
                      : park[`MRFD_ODT_BUF_BIT];
    cfg_d.parityOn       = (parCode != `MRFD_ZERO_3) && (parCode <= `MRFD_PAR_MAX_CODE);
    cfg_d.parityLatency  = parityClocks(parCode);
    cfg_d.parityReserved = parCode > `MRFD_PAR_MAX_CODE;
    cfg_d.spacingReserved = spcCode > `MRFD_SPC_MAX_CODE;
    cfg_d.columnSpacing  = cfg_d.spacingReserved ? `MRFD_ZERO_4
                           : `MRFD_SPC_BASE + {1'b0, spcCode};
    cfg_d.dllLockTime    = lockTime(spcCode);
    cfg_d.trainEnable    = spc[`MRFD_TRAIN_EN_BIT];
    cfg_d.trainRange     = spc[`MRFD_TRAIN_RANGE_BIT];
    cfg_d.trainValue     = spc[`MRFD_TRAIN_VAL_HI:`MRFD_TRAIN_VAL_LO];
    cfg_d.trainReserved  = cfg_d.trainValue > `MRFD_TRAIN_VAL_MAX;
    // Flag only; the device does not police the controller's reserved bits
    cfg_d.reservedBitsSet = (cmd.valid && cmd.select == `MRFD_SEL_SPACING)
                            ? (cmd.bankGroup1 | (|(cmd.opcode & `MRFD_RSV_MASK)))
                            : cfg_q.reservedBitsSet;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg = cfg_q;

  // Register view straight from the bank flops
  always_comb begin
    for (int i = 0; i < `MRFD_NUM_REGS; i++) begin
      regView[i] = modeReg_q[i];
    end
  end

endmodule

`default_nettype wire

// File: sim/mrfd_ctrl_model.sv
/*
  Controller model: issues one-cycle mode-register-set commands.
  Assumes the bench calls send and the decoder samples on rising clk.
*/
`timescale 1ns/10ps
`default_nettype none
module mrfd_ctrl_model (
  input  wire logic                clk,
  output var  mrfd_pkg::mrfd_cmd_s cmd
);
  import mrfd_pkg::*;
  initial cmd = '0;
  // Sequences and codes are the caller's choice; reserved bits are cleared in select 110 words
  // Idle lines show inverted data so a stale word is never mistaken for live
  task automatic send(input logic [2:0] sel, input mrfd_word_t op);
    mrfd_word_t w;
    w = (sel == 3'h6) ? (op & ~18'h22300) : op;
    @(negedge clk);
    cmd <= '{1'b1, 1'b0, sel, w};
    @(negedge clk);
    cmd <= '{1'b0, 1'b1, ~sel, ~w};
  endtask
endmodule
`default_nettype wire

// File: sim/mrfd_decoder_assertions.sv
/*
  Port checker for the mode register decoder.
  Assumes it is bound onto every decoder instance.
*/
`timescale 1ns/10ps
`default_nettype none
module mrfd_decoder_assertions (
  input wire logic                clk,
  input wire logic                reset,
  input wire mrfd_pkg::mrfd_cmd_s cmd,
  input wire mrfd_pkg::mrfd_cfg_s cfg,
  input wire mrfd_pkg::mrfd_word_t regView [7]
);
  import mrfd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_sel_latch: assert property (cmd.valid && cmd.select != 3'h7 |=>
    regView[$past(cmd.select)] == $past(cmd.opcode)) else $error("word not latched");
  chk_ctrl_ignored: assert property (cmd.valid && cmd.select == 3'h7 |=>
    $stable(cfg) && $stable(regView[6])) else $error("control word acted on");
  chk_park_map: assert property (cmd.valid && cmd.select == 3'h5 |=>
    cfg.parkTerm == mrfd_park_e'({1'b0, $past(cmd.opcode[8:6])})) else $error("park bad");
  chk_par_lat: assert property (cmd.valid && cmd.select == 3'h5 && cmd.opcode[2:0] == 3'h4
    |=> cfg.parityOn && cfg.parityLatency == 4'h8) else $error("latency bad");
  chk_spc_lock: assert property (cmd.valid && cmd.select == 3'h6 && cmd.opcode[12:10] == 3'h0
    |=> cfg.columnSpacing == 4'h4 && cfg.dllLockTime == 11'h255) else $error("spacing bad");
  chk_train_bits: assert property (cmd.valid && cmd.select == 3'h6 |=>
    cfg.trainEnable == $past(cmd.opcode[7]) && cfg.trainRange == $past(cmd.opcode[6]))
    else $error("training bits bad");
  chk_odt_gate: assert property (cfg.odtBufOff ==
    (regView[5][5] && (regView[1][9] || regView[1][6] || regView[1][2]))) else $error("odt bad");
  chk_train_rsv: assert property (cfg.trainReserved == (regView[6][5:0] > 6'h32))
    else $error("reserved level code bad");
endmodule
bind mrfd_decoder mrfd_decoder_assertions u_mrfd_decoder_assertions (.clk(clk), .reset(reset),
  .cmd(cmd), .cfg(cfg), .regView(regView));
`default_nettype wire

// File: sim/tb.sv
/*
  Self-checking bench for the mode register decoder.
  Assumes the controller model and the bound checker compile alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mrfd_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  int         n_errors = 0;
  int         total_checks = 0;
  mrfd_cmd_s  cmd;
  mrfd_cfg_s  cfg;
  mrfd_cfg_s  snap;
  mrfd_word_t regView [7];
  logic [3:0] parTab [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0, 4'h0};
  logic [10:0] lockTab [8] = '{11'h255, 11'h187, 11'h300, 11'h400, 11'h400, 11'h000, 11'h000,
                               11'h000};
  always #4 clk = ~clk;
  mrfd_decoder u_mrfd_decoder (.clk(clk), .reset(reset), .cmd(cmd), .cfg(cfg),
    .regView(regView));
  mrfd_ctrl_model u_mrfd_ctrl_model (.clk(clk), .cmd(cmd));
  // Case equality so an unknown never passes
  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    chk("reset cfg", 40'h0, 40'(cfg));
    $display("test reset done");
    u_mrfd_ctrl_model.send(3'h1, 18'h00004);
    for (int i = 0; i < 8; i++) begin
      u_mrfd_ctrl_model.send(3'h5, 18'(i * 64 + 32 + i));
      chk("park", 40'(i), 40'(cfg.parkTerm));
      chk("latency", 40'(parTab[i]), 40'(cfg.parityLatency));
      chk("parity on", 40'(i >= 1 && i <= 4), 40'(cfg.parityOn));
      chk("parity rsv", 40'(i >= 5), 40'(cfg.parityReserved));
      chk("odt on", 40'h1, 40'(cfg.odtBufOff));
    end
    u_mrfd_ctrl_model.send(3'h1, 18'h00000);
    chk("odt gated", 40'h0, 40'(cfg.odtBufOff));
    $display("test park parity done");
    for (int i = 0; i < 8; i++) begin
      u_mrfd_ctrl_model.send(3'h6, 18'(i * 1024 + i[0] * 64 + 128 + 47 + i));
      chk("spacing", 40'((i < 5) ? 4 + i : 0), 40'(cfg.columnSpacing));
      chk("lock", 40'(lockTab[i]), 40'(cfg.dllLockTime));
      chk("spacing rsv", 40'(i >= 5), 40'(cfg.spacingReserved));
      chk("level", 40'(47 + i), 40'(cfg.trainValue));
      chk("rsv bits", 40'h0, 40'(cfg.reservedBitsSet));
      chk("train", 40'({1'b1, i[0]}), 40'({cfg.trainEnable, cfg.trainRange}));
      chk("level rsv", 40'(i >= 4), 40'(cfg.trainReserved));
    end
    $display("test spacing training done");
    snap = cfg;
    u_mrfd_ctrl_model.send(3'h7, 18'h3FFFF);
    chk("ignored cfg", 40'(snap), 40'(cfg));
    chk("ignored reg", 40'h01CF6, 40'(regView[6]));
    $display("test control word done");
    for (int i = 0; i < 7; i++) u_mrfd_ctrl_model.send(3'(i), 18'(i * 1024 + i));
    for (int i = 0; i < 7; i++) chk("regView", 40'(i * 1024 + i), 40'(regView[i]));
    $display("test select done");
    results();
  end
endmodule
`default_nettype wire
